// file: uart_enh_pkg.sv
/*
  Shared constants and state types for the enhanced serial port receiver,
  transmitter, bit timer and address matcher.
  Assumes one synchronous clock domain and a synchronous active-low reset.
*/
package uart_enh_pkg;

  // ****************************************************************
  // Serial modes, {mode bit 0, mode bit 1}
  // ****************************************************************
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_UART8 = 2'h1;

  // ****************************************************************
  // Frame sizes, reset values and divider width limits
  // ****************************************************************
  localparam logic [3:0] BITS_UART8  = 4'h8;
  localparam logic [3:0] BITS_UART9  = 4'h9;
  localparam logic [7:0] ADDR_RESET  = 8'h00;
  localparam logic [7:0] MASK_RESET  = 8'h00;
  localparam int         DIV_W_MIN   = 2;
  localparam int         DIV_W_MAX   = 24;

  // ****************************************************************
  // State machines
  // ****************************************************************
  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_DATA  = 4'h4,
    RX_STOP  = 4'h8
  } rx_state_t;

  typedef enum logic [3:0] {
    TX_IDLE  = 4'h1,
    TX_START = 4'h2,
    TX_DATA  = 4'h4,
    TX_STOP  = 4'h8
  } tx_state_t;

  typedef struct packed {
    rx_state_t  rx_st;
    logic [3:0] rx_cnt;
    logic [8:0] rx_sh;
    logic       rx_prev;
    logic       rx_took;
    logic [7:0] rx_data;
    logic       rx_bit8;
    logic       ri;
    logic       fe;
    logic       ctrl7;
    logic [7:0] own_addr;
    logic [7:0] mask;
    tx_state_t  tx_st;
    logic [3:0] tx_cnt;
    logic [8:0] tx_sh;
    logic       txd;
    logic       ti;
    logic       tx_busy;
  } port_state_t;

  localparam port_state_t PORT_RESET = '{
    rx_st:    RX_IDLE,
    rx_cnt:   4'h0,
    rx_sh:    9'h000,
    rx_prev:  1'b1,
    rx_took:  1'b0,
    rx_data:  8'h00,
    rx_bit8:  1'b0,
    ri:       1'b0,
    fe:       1'b0,
    ctrl7:    1'b0,
    own_addr: ADDR_RESET,
    mask:     MASK_RESET,
    tx_st:    TX_IDLE,
    tx_cnt:   4'h0,
    tx_sh:    9'h000,
    txd:      1'b1,
    ti:       1'b0,
    tx_busy:  1'b0
  };

endpackage

// file: bit_timer.sv
/*
  Bit period timer: counts clock cycles of one serial bit and pulses at
  mid-bit and at bit end. Used once for receive, once for transmit.
  Assumes i_div, the cycles per bit, is at least 2 and steady in a frame.
*/
`timescale 1ns/1ps
module bit_timer import uart_enh_pkg::*; #(
  parameter int DIV_W = 16
) (
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  input  wire logic             i_restart,
  input  wire logic [DIV_W-1:0] i_div,
  output logic                  o_mid,
  output logic                  o_end
);

  // Refused at elaboration: the counter must be 2 to 24 bits wide
  if (DIV_W < DIV_W_MIN || DIV_W > DIV_W_MAX) begin
    $error("bit_timer: DIV_W out of range");
  end

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
  } timer_state_t;

  timer_state_t s_q;
  timer_state_t s_d;

  assign o_mid = s_q.cnt == (i_div >> 1);
  assign o_end = s_q.cnt == (i_div - DIV_W'(1));

  always_comb begin
    s_d = s_q;
    if (i_restart || o_end) begin
      s_d.cnt = '0;
    end else begin
      s_d.cnt = s_q.cnt + DIV_W'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// file: addr_match.sv
/*
  Address recognition: compares a received address byte with the given
  address and the broadcast address built from own address and mask.
  Purely combinational; assumes the caller registers the verdict.
*/
`timescale 1ns/1ps
module addr_match import uart_enh_pkg::*; (
  input  wire logic [7:0] i_own_address_byte,
  input  wire logic [7:0] i_address_mask_byte,
  input  wire logic [7:0] i_rx_byte,
  output logic            o_match
);

  logic [7:0] bcast;
  logic       given_hit;
  logic       bcast_hit;

  // Mask zero bits are don't-care
  assign given_hit = ((i_rx_byte ^ i_own_address_byte) & i_address_mask_byte) == 8'h00;
  // Ones of the OR must be received as ones
  assign bcast     = i_own_address_byte | i_address_mask_byte;
  assign bcast_hit = (~i_rx_byte & bcast) == 8'h00;
  assign o_match   = given_hit | bcast_hit;

endmodule

// file: uart_frame_check_addr_match.sv
/*
  Enhanced asynchronous serial port: full-duplex transmitter and receiver
  with framing error detection and automatic address recognition.
  Assumes all inputs synchronous to i_clk; control bits held steady by
  the CPU while a frame is in flight; mode 0 shift traffic handled elsewhere.
*/
`timescale 1ns/1ps

module uart_frame_check_addr_match import uart_enh_pkg::*; #(
  parameter int DIV_W = 16
) (
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  input  wire logic             i_rxd,
  input  wire logic             i_serial_mode_bit0,
  input  wire logic             i_serial_mode_bit1,
  input  wire logic             i_multiproc_enable,
  input  wire logic             i_rx_enable,
  input  wire logic             i_frame_check_enable,
  input  wire logic [DIV_W-1:0] i_rx_div,
  input  wire logic [DIV_W-1:0] i_tx_div,
  input  wire logic             i_own_address_wr,
  input  wire logic             i_address_mask_wr,
  input  wire logic [7:0]       i_wdata,
  input  wire logic             i_ri_clear,
  input  wire logic             i_ti_clear,
  input  wire logic             i_fe_clear,
  input  wire logic             i_tx_start,
  input  wire logic [7:0]       i_tx_data,
  input  wire logic             i_tx_bit8,
  output logic                  o_txd,
  output logic                  o_tx_busy,
  output logic [7:0]            o_rx_data,
  output logic                  o_rx_bit8,
  output logic                  o_receive_irq_flag,
  output logic                  o_transmit_irq_flag,
  output logic                  o_framing_error_flag,
  output logic                  o_ctrl_bit7,
  output logic [7:0]            o_own_address_byte,
  output logic [7:0]            o_address_mask_byte
);

  // ****************************************************************
  // Parameter check
  // ****************************************************************
  // Refused at elaboration, before any logic is built
  if (DIV_W < DIV_W_MIN || DIV_W > DIV_W_MAX) begin
    $error("uart_frame_check_addr_match: DIV_W out of range");
  end

  // ****************************************************************
  // State and helpers
  // ****************************************************************
  port_state_t s_q;
  port_state_t s_d;

  logic [1:0] mode;
  logic       async_mode;
  logic       is_uart8;
  logic       mp_on;
  logic       fe_on;
  logic       late;
  logic [3:0] nbits;
  logic [8:0] cand;
  logic [7:0] fr_data;
  logic       fr_b8;
  logic       match;
  logic       rx_restart;
  logic       tx_restart;
  logic       rx_mid;
  logic       tx_end;

  // Mode 0 shift traffic is not served; starts are ignored there
  assign mode       = {i_serial_mode_bit0, i_serial_mode_bit1};
  assign async_mode = mode != MODE_SHIFT;
  assign is_uart8   = mode == MODE_UART8;
  assign mp_on      = i_multiproc_enable & async_mode;
  assign fe_on      = i_frame_check_enable & async_mode;
  // Decide at stop when the stop bit matters
  assign late       = fe_on | (is_uart8 & mp_on);
  assign nbits      = is_uart8 ? BITS_UART8 : BITS_UART9;

  // Frame as it stands after this sample
  assign cand    = (s_q.rx_st == RX_STOP) ? s_q.rx_sh : {i_rxd, s_q.rx_sh[8:1]};
  assign fr_data = is_uart8 ? cand[8:1] : cand[7:0];
  assign fr_b8   = cand[8];

  // ****************************************************************
  // Bit timers and address matcher
  // ****************************************************************
  // Separate timers let the two directions run at different rates
  bit_timer #(
    .DIV_W     (DIV_W)
  ) u_rx_timer (
    .i_clk     (i_clk),
    .i_rstn    (i_rstn),
    .i_restart (rx_restart),
    .i_div     (i_rx_div),
    .o_mid     (rx_mid),
    .o_end     ()
  );

  bit_timer #(
    .DIV_W     (DIV_W)
  ) u_tx_timer (
    .i_clk     (i_clk),
    .i_rstn    (i_rstn),
    .i_restart (tx_restart),
    .i_div     (i_tx_div),
    .o_mid     (),
    .o_end     (tx_end)
  );

  addr_match u_match (
    .i_own_address_byte  (s_q.own_addr),
    .i_address_mask_byte (s_q.mask),
    .i_rx_byte           (fr_data),
    .o_match             (match)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic ri_set;
    logic fe_set;
    logic ti_set;
    logic decide;
    logic accept;
    ri_set     = 1'b0;
    fe_set     = 1'b0;
    ti_set     = 1'b0;
    decide     = 1'b0;
    accept     = 1'b0;
    rx_restart = 1'b0;
    tx_restart = 1'b0;
    s_d        = s_q;
    s_d.rx_prev = i_rxd;

    // Receiver
    case (s_q.rx_st)
      RX_IDLE: begin
        // A low sample after a high one starts a frame
        if (async_mode && i_rx_enable && s_q.rx_prev && !i_rxd) begin
          rx_restart = 1'b1;
          s_d.rx_cnt = 4'h0;
          s_d.rx_took = 1'b0;
          s_d.rx_st  = RX_START;
        end
      end
      RX_START: begin
        if (rx_mid) begin
          // A high start bit at mid-bit is a glitch
          s_d.rx_st = i_rxd ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (rx_mid) begin
          s_d.rx_sh  = cand;
          s_d.rx_cnt = s_q.rx_cnt + 4'h1;
          if (s_q.rx_cnt + 4'h1 == nbits) begin
            s_d.rx_st = RX_STOP;
            decide    = !late;
          end
        end
      end
      RX_STOP: begin
        if (rx_mid) begin
          s_d.rx_st = RX_IDLE;
          fe_set    = fe_on && !i_rxd;
          decide    = late;
          // Mode 1 ninth bit is the stop bit
          if (is_uart8 && s_q.rx_took) begin
            s_d.rx_bit8 = i_rxd;
          end
        end
      end
      default: begin
        s_d.rx_st = RX_IDLE;
      end
    endcase

    if (decide) begin
      // An unread byte is kept rather than overwritten
      if (!s_q.ri) begin
        if (!mp_on) begin
          accept = 1'b1;
        end else if (is_uart8) begin
          accept = match && i_rxd;
        end else begin
          accept = match && fr_b8;
        end
      end
      if (accept) begin
        ri_set      = 1'b1;
        s_d.rx_data = fr_data;
        s_d.rx_took = 1'b1;
        if (is_uart8) begin
          s_d.rx_bit8 = i_rxd;
        end else begin
          s_d.rx_bit8 = fr_b8;
        end
      end
    end

    // Transmitter
    case (s_q.tx_st)
      TX_IDLE: begin
        if (i_tx_start && async_mode) begin
          tx_restart = 1'b1;
          s_d.tx_sh  = {i_tx_bit8, i_tx_data};
          s_d.tx_cnt = 4'h0;
          s_d.txd    = 1'b0;
          s_d.tx_st  = TX_START;
        end
      end
      TX_START: begin
        if (tx_end) begin
          s_d.txd   = s_q.tx_sh[0];
          s_d.tx_sh = {1'b0, s_q.tx_sh[8:1]};
          s_d.tx_st = TX_DATA;
        end
      end
      TX_DATA: begin
        if (tx_end) begin
          s_d.tx_cnt = s_q.tx_cnt + 4'h1;
          if (s_q.tx_cnt + 4'h1 == nbits) begin
            s_d.txd   = 1'b1;
            s_d.tx_st = TX_STOP;
            ti_set    = 1'b1;
          end else begin
            s_d.txd   = s_q.tx_sh[0];
            s_d.tx_sh = {1'b0, s_q.tx_sh[8:1]};
          end
        end
      end
      TX_STOP: begin
        if (tx_end) begin
          s_d.tx_st = TX_IDLE;
        end
      end
      default: begin
        s_d.tx_st = TX_IDLE;
      end
    endcase
    s_d.tx_busy = s_d.tx_st != TX_IDLE;

    // Sticky flags: a hardware set beats a same-cycle clear
    s_d.ri = (s_q.ri && !i_ri_clear) || ri_set;
    s_d.ti = (s_q.ti && !i_ti_clear) || ti_set;
    s_d.fe = (s_q.fe && !i_fe_clear) || fe_set;

    if (i_own_address_wr) begin
      s_d.own_addr = i_wdata;
    end
    if (i_address_mask_wr) begin
      s_d.mask = i_wdata;
    end

    s_d.ctrl7 = i_frame_check_enable ? s_d.fe : i_serial_mode_bit0;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      s_q <= PORT_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_txd                = s_q.txd;
  assign o_tx_busy            = s_q.tx_busy;
  assign o_rx_data            = s_q.rx_data;
  assign o_rx_bit8            = s_q.rx_bit8;
  assign o_receive_irq_flag   = s_q.ri;
  assign o_transmit_irq_flag  = s_q.ti;
  assign o_framing_error_flag = s_q.fe;
  assign o_ctrl_bit7          = s_q.ctrl7;
  assign o_own_address_byte   = s_q.own_addr;
  assign o_address_mask_byte  = s_q.mask;

endmodule

// file: serial_master_model.sv
/*
  Serial line master: sends start, data, optional ninth bit and stop.
  Assumes the receiver samples its line on the rising edge of i_clk.
*/
`timescale 1ns/1ps
module serial_master_model (
  input  wire logic i_clk,
  output logic      o_line
);
  // ****
  // Line driver
  // ****
  initial o_line = 1'b1;

  // Address frames carry ninth bit one when asked
  task automatic send(input logic [7:0] b, input logic nine, input logic b8,
                      input logic stop, input int div);
    logic [10:0] f;
    int          n;
    f = {stop, b8, b, 1'b0};
    n = nine ? 11 : 10;
    if (!nine) begin
      f[9] = stop;
    end
    for (int i = 0; i < n; i++) begin
      repeat (div) @(posedge i_clk) o_line <= f[i];
    end
    // Idle gap at mark level, so a bad stop still ends high
    repeat (div) @(posedge i_clk) o_line <= 1'b1;
  endtask
endmodule

// file: uart_check_asserts.sv
/*
  Checker for the enhanced serial port top module.
  Assumes one clock, synchronous active-low reset; bound below.
*/
`timescale 1ns/1ps
module uart_check_asserts (
  input wire logic       i_clk,
  input wire logic       i_rstn,
  input wire logic       i_rxd,
  input wire logic       i_serial_mode_bit0,
  input wire logic       i_serial_mode_bit1,
  input wire logic       i_frame_check_enable,
  input wire logic       i_own_address_wr,
  input wire logic       i_address_mask_wr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_fe_clear,
  input wire logic       i_tx_start,
  input wire logic       o_txd,
  input wire logic       o_tx_busy,
  input wire logic       o_receive_irq_flag,
  input wire logic       o_transmit_irq_flag,
  input wire logic       o_framing_error_flag,
  input wire logic       o_ctrl_bit7,
  input wire logic [7:0] o_own_address_byte,
  input wire logic [7:0] o_address_mask_byte
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  a_fe_sticky: assert property (o_framing_error_flag && !i_fe_clear |=> o_framing_error_flag)
    else $error("framing flag dropped");
  a_fe_cause: assert property ($rose(o_framing_error_flag) |-> $past(i_frame_check_enable))
    else $error("framing flag without check");
  a_ctrl_bit7: assert property ($past(i_rstn) |-> o_ctrl_bit7 ==
    ($past(i_frame_check_enable) ? o_framing_error_flag : $past(i_serial_mode_bit0)))
    else $error("control bit 7 wrong source");
  a_own_write: assert property ($past(i_rstn) |-> o_own_address_byte ==
    ($past(i_own_address_wr) ? $past(i_wdata) : $past(o_own_address_byte)))
    else $error("own address byte wrong");
  a_mask_write: assert property ($past(i_rstn) |-> o_address_mask_byte ==
    ($past(i_address_mask_wr) ? $past(i_wdata) : $past(o_address_mask_byte)))
    else $error("mask byte wrong");
  a_tx_start: assert property (i_tx_start && !o_tx_busy &&
    (i_serial_mode_bit0 || i_serial_mode_bit1) |=> o_tx_busy && !o_txd)
    else $error("transmit start not taken");
  a_tx_mode0: assert property (i_tx_start && !o_tx_busy && !i_serial_mode_bit0 &&
    !i_serial_mode_bit1 |=> !o_tx_busy)
    else $error("transmit started in mode 0");
  a_ti_stop: assert property ($rose(o_transmit_irq_flag) |-> o_txd && o_tx_busy)
    else $error("transmit flag not at stop bit");
  a_ri_at_stop: assert property ($rose(o_receive_irq_flag) && i_frame_check_enable &&
    !$past(o_framing_error_flag) |-> o_framing_error_flag == !$past(i_rxd))
    else $error("receive flag not at stop sample");
endmodule

bind uart_frame_check_addr_match uart_check_asserts i_chk (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_rxd(i_rxd),
  .i_serial_mode_bit0(i_serial_mode_bit0), .i_serial_mode_bit1(i_serial_mode_bit1),
  .i_frame_check_enable(i_frame_check_enable), .i_own_address_wr(i_own_address_wr),
  .i_address_mask_wr(i_address_mask_wr), .i_wdata(i_wdata), .i_fe_clear(i_fe_clear),
  .i_tx_start(i_tx_start), .o_txd(o_txd), .o_tx_busy(o_tx_busy),
  .o_receive_irq_flag(o_receive_irq_flag), .o_transmit_irq_flag(o_transmit_irq_flag),
  .o_framing_error_flag(o_framing_error_flag), .o_ctrl_bit7(o_ctrl_bit7),
  .o_own_address_byte(o_own_address_byte), .o_address_mask_byte(o_address_mask_byte));

// file: tb_top.sv
/*
  Testbench: address rows in a loop, then framing, mode 1, mode 0, duplex.
  Assumes the serial master model and the bound checker are compiled.
*/
`timescale 1ns/1ps
module tb_top;
  import uart_enh_pkg::*;
  typedef struct packed {logic [7:0] a, m, rx; logic b8, exp;} row_t;
  localparam row_t ROWS [10] = '{
    '{8'hf1, 8'hfa, 8'hf0, 1'b1, 1'b1}, '{8'hf1, 8'hfa, 8'hf3, 1'b1, 1'b0},
    '{8'hf1, 8'hfa, 8'hff, 1'b1, 1'b1}, '{8'hf1, 8'hfa, 8'hfb, 1'b1, 1'b1},
    '{8'hf2, 8'hfd, 8'hfb, 1'b1, 1'b0}, '{8'hf2, 8'hfd, 8'hf0, 1'b1, 1'b1},
    '{8'h56, 8'hff, 8'h56, 1'b1, 1'b1}, '{8'h56, 8'hff, 8'h57, 1'b1, 1'b0},
    '{8'h00, 8'h00, 8'h9c, 1'b1, 1'b1}, '{8'h00, 8'h00, 8'h9c, 1'b0, 1'b0}};
  localparam logic [9:0] TX_FRAME = {1'b1, 8'ha5, 1'b0};
  logic        clk = 1'b0, rstn = 1'b0, m0 = 1'b0, m1 = 1'b1, mp = 1'b0, fce = 1'b0;
  logic        own_wr = 1'b0, mask_wr = 1'b0, ri_clr = 1'b0, fe_clr = 1'b0, tx_go = 1'b0;
  logic        rx_en = 1'b1, ti_clr = 1'b0;
  logic [7:0]  wdata = 8'h00, rx_data, own, mask;
  logic        rxd, txd, busy, rx_b8, ri, ti, fe, c7;
  int          n_fail = 0, samples_checked = 0;

  always #5 clk = ~clk;

  uart_frame_check_addr_match #(.DIV_W(16)) i_dut (
    .i_clk(clk), .i_rstn(rstn), .i_rxd(rxd), .i_serial_mode_bit0(m0),
    .i_serial_mode_bit1(m1), .i_multiproc_enable(mp), .i_rx_enable(rx_en),
    .i_frame_check_enable(fce), .i_rx_div(16'h0004), .i_tx_div(16'h0006),
    .i_own_address_wr(own_wr), .i_address_mask_wr(mask_wr), .i_wdata(wdata),
    .i_ri_clear(ri_clr), .i_ti_clear(ti_clr), .i_fe_clear(fe_clr), .i_tx_start(tx_go),
    .i_tx_data(8'ha5), .i_tx_bit8(1'b0), .o_txd(txd), .o_tx_busy(busy),
    .o_rx_data(rx_data), .o_rx_bit8(rx_b8), .o_receive_irq_flag(ri),
    .o_transmit_irq_flag(ti), .o_framing_error_flag(fe), .o_ctrl_bit7(c7),
    .o_own_address_byte(own), .o_address_mask_byte(mask));
  serial_master_model i_master (.i_clk(clk), .o_line(rxd));

  // ****
  // Helpers
  // ****
  task automatic chk1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic set_am(input logic [7:0] a, input logic [7:0] m);
    @(posedge clk) {own_wr, wdata} <= {1'b1, a};
    @(posedge clk) {own_wr, mask_wr, wdata} <= {2'b01, m};
    @(posedge clk) mask_wr <= 1'b0;
  endtask
  task automatic clr(input logic with_fe);
    @(posedge clk) {ri_clr, fe_clr} <= {1'b1, with_fe};
    @(posedge clk) {ri_clr, fe_clr} <= 2'b00;
  endtask
  task automatic rx(input logic [7:0] b, input logic nine, input logic b8, input logic stop);
    i_master.send(b, nine, b8, stop, 4);
    tick(2);
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ****
  // Sequence
  // ****
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    tick(1);
    chk8(own, 8'h00);
    chk8(mask, 8'h00);
    chk1(fe, 1'b0);
    @(posedge clk) {m0, mp} <= 2'b11;
    foreach (ROWS[i]) begin
      set_am(ROWS[i].a, ROWS[i].m);
      rx(ROWS[i].rx, 1'b1, ROWS[i].b8, 1'b1);
      chk1(ri, ROWS[i].exp);
      if (ROWS[i].exp) begin
        chk8(rx_data, ROWS[i].rx);
        chk1(rx_b8, ROWS[i].b8);
      end
      clr(1'b0);
    end
    // Framing check in mode 1, no address recognition
    @(posedge clk) {m0, mp, fce} <= 3'b001;
    rx(8'h5a, 1'b0, 1'b0, 1'b0);
    chk1(fe, 1'b1);
    chk1(ri, 1'b1);
    chk1(c7, 1'b1);
    clr(1'b0);
    rx(8'h5a, 1'b0, 1'b0, 1'b1);
    chk1(fe, 1'b1);
    clr(1'b1);
    tick(1);
    chk1(fe, 1'b0);
    @(posedge clk) fce <= 1'b0;
    rx(8'h11, 1'b0, 1'b0, 1'b0);
    chk1(fe, 1'b0);
    chk1(c7, 1'b0);
    clr(1'b0);
    // Mode 1 address recognition needs a good stop bit
    @(posedge clk) mp <= 1'b1;
    set_am(8'h33, 8'hff);
    rx(8'h33, 1'b0, 1'b0, 1'b0);
    chk1(ri, 1'b0);
    rx(8'h34, 1'b0, 1'b0, 1'b1);
    chk1(ri, 1'b0);
    rx(8'h33, 1'b0, 1'b0, 1'b1);
    chk1(ri, 1'b1);
    chk1(rx_b8, 1'b1);
    clr(1'b0);
    // Mode 0 takes no transmit start
    @(posedge clk) {m1, tx_go} <= 2'b01;
    @(posedge clk) tx_go <= 1'b0;
    tick(2);
    chk1(busy, 1'b0);
    // Duplex: transmit at 6 cycles a bit while receiving at 4
    @(posedge clk) {m1, mp, tx_go} <= 3'b101;
    fork
      i_master.send(8'h3c, 1'b0, 1'b0, 1'b1, 4);
    join_none
    @(posedge clk) tx_go <= 1'b0;
    tick(3);
    for (int i = 0; i < 10; i++) begin
      chk1(txd, TX_FRAME[i]);
      chk1(busy, 1'b1);
      tick(6);
    end
    chk1(busy, 1'b0);
    chk1(ti, 1'b1);
    chk1(ri, 1'b1);
    chk8(rx_data, 8'h3c);
    // Flags cleared, then a frame with reception off must leave them low
    @(posedge clk) {ri_clr, ti_clr, rx_en} <= 3'b110;
    @(posedge clk) {ri_clr, ti_clr} <= 2'b00;
    rx(8'h77, 1'b0, 1'b0, 1'b1);
    chk1(ti, 1'b0);
    chk1(ri, 1'b0);
    chk8(rx_data, 8'h3c);
    // Mid-run reset brings address and mask back to zero
    @(posedge clk) {rstn, rx_en} <= 2'b01;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    tick(1);
    chk8(own, 8'h00);
    chk8(mask, 8'h00);
    tally_and_finish;
  end

  // Far longer than the sequence, which needs about 970 cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    tally_and_finish;
  end
endmodule
